// *** hw/uart_display_command_link.sv ***
// Overview of operation
// - Link fixed at 115200 baud, 8N1
// - Verify checksum before dispatching the command
// - Codes 0x50 to 0x5F never commands
// - Good command: execute and echo function code
// - Good bulk frame answered 0x55 0xAA
// - Error: code then function code or 0x55 0xAA
// - Checksum error 0x58, timeout 0x54; host resends
// - Leaving a busy spell begun mid-frame sends 0x53 plus stage tail
// - Touch reported as 0x50, X, Y
// - No touch reports during bulk stage
// - Only 0x21 and 0x24 start bulk stage
// - Bulk: 0x55 0xAA, length minus one, data
`timescale 1ns/1ps
module uart_display_command_link
  import dcl_pkg::*;
#(
  parameter int RX_TMO_CYC = RX_TMO_DEF
) (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   arst_n,
  // Serial link
  input  wire logic   rxd,
  output logic        txd,
  // Command dispatch
  output logic        cmd_valid,
  output cmd_s        cmd,
  input  wire logic   engine_busy,
  // Bulk data
  output logic        bulk_valid,
  output logic [7:0]  bulk_byte,
  output logic        bulk_done,
  output logic        bulk_ok,
  // Touch events
  input  wire logic   touch_valid,
  input  wire touch_s touch
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000, S_PARAM = 3'b001, S_CSUM  = 3'b011,
    S_BWAIT = 3'b010, S_BAA   = 3'b110, S_BLEN  = 3'b111,
    S_BDATA = 3'b101, S_BCSUM = 3'b100
  } frame_e;

  frame_e      state_reg;
  logic        rx_act_reg, rx_stb_reg, tx_act_reg, txd_reg;
  logic [15:0] rx_cnt_reg, tx_cnt_reg;
  logic [3:0]  rx_bit_reg, tx_bit_reg, pcnt_reg, need_reg;
  logic [7:0]  rx_sh_reg, rx_byte_reg, sum_reg, len_reg, bcnt_reg;
  logic [8:0]  tx_sh_reg;
  logic [31:0] tmo_reg;
  logic        resp_pend_reg, resp_has_hdr_reg, resp_bulk_reg;
  logic [7:0]  resp_hdr_reg;
  logic        note_pend_reg, waited_reg, busy_q_reg;
  logic [7:0]  note_hdr_reg;
  logic        touch_pend_reg;
  touch_s      touch_reg;
  logic [39:0] msg_reg, msg_next;
  logic [2:0]  left_reg, len_next;
  logic [15:0] tail;
  logic [1:0]  tail_len;
  logic        in_bulk, msg_free, take_resp, take_note, take_touch;
  logic        csum_hit, tmo_hit, reserved, tail_bulk, has_hdr;
  logic [7:0]  hdr;

  assign txd      = txd_reg;
  assign in_bulk  = state_reg inside {S_BWAIT, S_BAA, S_BLEN, S_BDATA,
                                      S_BCSUM};
  assign csum_hit = (rx_byte_reg == sum_reg);
  assign reserved = (rx_byte_reg >= RSV_LO) && (rx_byte_reg <= RSV_HI);
  assign tmo_hit  = (tmo_reg == 32'(RX_TMO_CYC - 1));

  // ----------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_act_reg  <= 1'b0;
      rx_stb_reg  <= 1'b0;
      rx_cnt_reg  <= 16'h0;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 8'h00;
      rx_byte_reg <= 8'h00;
    end else begin
      rx_stb_reg <= 1'b0;
      if (!rx_act_reg) begin
        if (!rxd) begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= 16'(HALF_BIT);
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != 16'h0) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h1;
      end else begin
        rx_cnt_reg <= 16'(BIT_CYC - 1);
        if (rx_bit_reg == 4'h0) begin
          // A glitch that is gone by mid-bit is not a start bit
          rx_act_reg <= ~rxd;
          rx_bit_reg <= 4'h1;
        end else if (rx_bit_reg < 4'h9) begin
          rx_sh_reg  <= {rxd, rx_sh_reg[7:1]};
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end else begin
          rx_act_reg  <= 1'b0;
          rx_stb_reg  <= rxd;
          rx_byte_reg <= rx_sh_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame parser and answers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg        <= S_IDLE;
      cmd              <= '0;
      cmd_valid        <= 1'b0;
      bulk_valid       <= 1'b0;
      bulk_byte        <= 8'h00;
      bulk_done        <= 1'b0;
      bulk_ok          <= 1'b0;
      pcnt_reg         <= 4'h0;
      need_reg         <= 4'h0;
      sum_reg          <= 8'h00;
      len_reg          <= 8'h00;
      bcnt_reg         <= 8'h00;
      tmo_reg          <= 32'h0;
      resp_pend_reg    <= 1'b0;
      resp_has_hdr_reg <= 1'b0;
      resp_bulk_reg    <= 1'b0;
      resp_hdr_reg     <= 8'h00;
    end else begin
      cmd_valid  <= 1'b0;
      bulk_valid <= 1'b0;
      bulk_done  <= 1'b0;
      if (take_resp) begin
        resp_pend_reg <= 1'b0;
      end
      // Host may sit idle between stages, so no timeout there
      if (rx_stb_reg || state_reg == S_IDLE || state_reg == S_BWAIT) begin
        tmo_reg <= 32'h0;
      end else if (!engine_busy) begin
        tmo_reg <= tmo_reg + 32'h1;
      end
      if (tmo_hit && !rx_stb_reg && !engine_busy &&
          state_reg != S_IDLE && state_reg != S_BWAIT) begin
        resp_pend_reg    <= 1'b1;
        resp_has_hdr_reg <= 1'b1;
        resp_hdr_reg     <= MSG_TIMEOUT;
        resp_bulk_reg    <= in_bulk;
        state_reg        <= in_bulk ? S_BWAIT : S_IDLE;
      end else if (rx_stb_reg) begin
        unique case (state_reg)
          S_IDLE: begin
            if (!reserved) begin
              cmd.code    <= rx_byte_reg;
              cmd.nparams <= param_len(rx_byte_reg);
              need_reg    <= param_len(rx_byte_reg);
              sum_reg     <= rx_byte_reg;
              pcnt_reg    <= 4'h0;
              state_reg   <= (param_len(rx_byte_reg) == 4'h0) ? S_CSUM
                                                              : S_PARAM;
            end
          end
          S_PARAM: begin
            cmd.params[pcnt_reg[2:0]*8 +: 8] <= rx_byte_reg;
            sum_reg  <= csum_add(sum_reg, rx_byte_reg);
            pcnt_reg <= pcnt_reg + 4'h1;
            if (pcnt_reg == need_reg - 4'h1) begin
              state_reg <= S_CSUM;
            end
          end
          S_CSUM: begin
            resp_pend_reg <= 1'b1;
            resp_bulk_reg <= 1'b0;
            if (csum_hit) begin
              cmd_valid        <= 1'b1;
              resp_has_hdr_reg <= 1'b0;
              // Host holds write data until the echo has gone out
              state_reg <= (cmd.code == STORAGE_IMAGE_WRITE_CMD ||
                            cmd.code == DISPLAY_BLOCK_TRANSFER_CMD)
                           ? S_BWAIT : S_IDLE;
            end else begin
              resp_has_hdr_reg <= 1'b1;
              resp_hdr_reg     <= MSG_WRONG;
              state_reg        <= S_IDLE;
            end
          end
          S_BWAIT: begin
            if (rx_byte_reg == BULK_LEAD0) begin
              sum_reg   <= rx_byte_reg;
              state_reg <= S_BAA;
            end
          end
          S_BAA: begin
            sum_reg   <= csum_add(sum_reg, rx_byte_reg);
            state_reg <= (rx_byte_reg == BULK_LEAD1) ? S_BLEN : S_BWAIT;
          end
          S_BLEN: begin
            sum_reg   <= csum_add(sum_reg, rx_byte_reg);
            len_reg   <= rx_byte_reg;
            bcnt_reg  <= 8'h00;
            state_reg <= S_BDATA;
          end
          S_BDATA: begin
            sum_reg    <= csum_add(sum_reg, rx_byte_reg);
            bulk_valid <= 1'b1;
            bulk_byte  <= rx_byte_reg;
            bcnt_reg   <= bcnt_reg + 8'h01;
            if (bcnt_reg == len_reg) begin
              state_reg <= S_BCSUM;
            end
          end
          S_BCSUM: begin
            bulk_done        <= 1'b1;
            bulk_ok          <= csum_hit;
            resp_pend_reg    <= 1'b1;
            resp_bulk_reg    <= 1'b1;
            resp_has_hdr_reg <= ~csum_hit;
            resp_hdr_reg     <= MSG_WRONG;
            state_reg        <= csum_hit ? S_IDLE : S_BWAIT;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Busy and ready notices
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q_reg    <= 1'b0;
      waited_reg    <= 1'b0;
      note_pend_reg <= 1'b0;
      note_hdr_reg  <= 8'h00;
    end else begin
      busy_q_reg <= engine_busy;
      if (take_note) begin
        note_pend_reg <= 1'b0;
      end
      if (engine_busy && !busy_q_reg && state_reg != S_IDLE) begin
        note_pend_reg <= 1'b1;
        note_hdr_reg  <= MSG_WAIT;
        waited_reg    <= 1'b1;
      end else if (!engine_busy && busy_q_reg && waited_reg) begin
        note_pend_reg <= 1'b1;
        note_hdr_reg  <= MSG_READY;
        waited_reg    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Touch capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      touch_pend_reg <= 1'b0;
      touch_reg      <= '0;
    end else begin
      if (take_touch || in_bulk) begin
        touch_pend_reg <= 1'b0;
      end
      if (touch_valid && !in_bulk) begin
        touch_pend_reg <= 1'b1;
        touch_reg      <= touch;
      end
    end
  end

  // ----------------------------------------------------------------
  // Message builder; protocol answers outrank notices and touches
  // ----------------------------------------------------------------
  assign msg_free   = !tx_act_reg && left_reg == 3'h0;
  assign take_resp  = msg_free && resp_pend_reg;
  assign take_note  = msg_free && !resp_pend_reg && note_pend_reg;
  assign take_touch = msg_free && !resp_pend_reg && !note_pend_reg &&
                      touch_pend_reg && !in_bulk;

  always_comb begin
    tail_bulk = take_resp ? resp_bulk_reg : in_bulk;
    has_hdr   = take_resp ? resp_has_hdr_reg : 1'b1;
    hdr       = take_resp ? resp_hdr_reg : note_hdr_reg;
    tail      = tail_bulk ? {BULK_LEAD0, BULK_LEAD1} : {cmd.code, 8'h00};
    tail_len  = tail_bulk ? 2'd2 : 2'd1;
    if (take_touch) begin
      msg_next = {MSG_TOUCH, touch_reg.x, touch_reg.y};
      len_next = 3'd5;
    end else if (has_hdr) begin
      msg_next = {hdr, tail, 16'h0000};
      len_next = 3'(tail_len) + 3'd1;
    end else begin
      msg_next = {tail, 24'h000000};
      len_next = 3'(tail_len);
    end
  end

  // ----------------------------------------------------------------
  // Serial transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_act_reg <= 1'b0;
      txd_reg    <= 1'b1;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg  <= 9'h1ff;
      msg_reg    <= 40'h0;
      left_reg   <= 3'h0;
    end else if (!tx_act_reg) begin
      if (left_reg != 3'h0) begin
        txd_reg    <= 1'b0;
        tx_sh_reg  <= {1'b1, msg_reg[39:32]};
        tx_bit_reg <= 4'h9;
        tx_cnt_reg <= 16'(BIT_CYC - 1);
        tx_act_reg <= 1'b1;
        msg_reg    <= {msg_reg[31:0], 8'h00};
        left_reg   <= left_reg - 3'h1;
      end else if (take_resp || take_note || take_touch) begin
        msg_reg  <= msg_next;
        left_reg <= len_next;
      end
    end else if (tx_cnt_reg != 16'h0) begin
      tx_cnt_reg <= tx_cnt_reg - 16'h1;
    end else if (tx_bit_reg == 4'h0) begin
      tx_act_reg <= 1'b0;
    end else begin
      txd_reg    <= tx_sh_reg[0];
      tx_sh_reg  <= {1'b1, tx_sh_reg[8:1]};
      tx_bit_reg <= tx_bit_reg - 4'h1;
      tx_cnt_reg <= 16'(BIT_CYC - 1);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_std_good;
    rx_stb_reg && state_reg == S_CSUM && csum_hit;
  endsequence

  sequence seq_std_bad;
    rx_stb_reg && state_reg == S_CSUM && !csum_hit && !tmo_hit;
  endsequence

  chk_reserved_skip: assert property (@(posedge mclk) disable iff (!arst_n)
    rx_stb_reg && state_reg == S_IDLE && reserved |=> state_reg == S_IDLE)
    else $error("reserved code started a frame");
  chk_dispatch_gate: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd_valid |-> $past(state_reg) == S_CSUM && $past(csum_hit))
    else $error("command dispatched without a good checksum");
  chk_echo_reply: assert property (@(posedge mclk) disable iff (!arst_n)
    seq_std_good |=> cmd_valid && resp_pend_reg && !resp_has_hdr_reg)
    else $error("good command not echoed");
  chk_wrong_reply: assert property (@(posedge mclk) disable iff (!arst_n)
    seq_std_bad |=> !cmd_valid && resp_hdr_reg == MSG_WRONG
                    && resp_has_hdr_reg && state_reg == S_IDLE)
    else $error("checksum failure not reported");
  chk_bulk_entry: assert property (@(posedge mclk) disable iff (!arst_n)
    seq_std_good ##1 (cmd.code == STORAGE_IMAGE_WRITE_CMD ||
                      cmd.code == DISPLAY_BLOCK_TRANSFER_CMD)
    |-> state_reg == S_BWAIT)
    else $error("bulk stage not entered");
  chk_bulk_reply: assert property (@(posedge mclk) disable iff (!arst_n)
    rx_stb_reg && state_reg == S_BCSUM && csum_hit && !tmo_hit
    |=> bulk_ok && resp_bulk_reg && !resp_has_hdr_reg ##1 !bulk_done)
    else $error("bulk success not answered");
  chk_touch_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    in_bulk |-> !take_touch ##1 !(left_reg == 3'd5 && !tx_act_reg))
    else $error("touch report sent in bulk stage");
  chk_touch_drop: assert property (@(posedge mclk) disable iff (!arst_n)
    in_bulk |=> !touch_pend_reg)
    else $error("touch kept pending in bulk stage");
  chk_ready_note: assert property (@(posedge mclk) disable iff (!arst_n)
    !engine_busy && busy_q_reg && waited_reg
    |=> note_pend_reg && note_hdr_reg == MSG_READY && !waited_reg)
    else $error("ready notice missing");
  chk_timeout_code: assert property (@(posedge mclk) disable iff (!arst_n)
    tmo_hit && !rx_stb_reg && !engine_busy && state_reg == S_PARAM
    |=> resp_hdr_reg == MSG_TIMEOUT && state_reg == S_IDLE)
    else $error("timeout not reported");

endmodule

// *** hw/dcl_pkg.sv ***
package dcl_pkg;

  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int BAUD_BPS    = 115200;
  localparam int BIT_CYC     = CLK_HZ / BAUD_BPS;
  localparam int HALF_BIT    = BIT_CYC / 2;
  localparam int RX_TMO_DEF  = 100_000;

  // ----------------------------------------------------------------
  // Message and command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MSG_WRONG      = 8'h58;
  localparam logic [7:0] MSG_WAIT       = 8'h57;
  localparam logic [7:0] MSG_READY      = 8'h53;
  localparam logic [7:0] MSG_TIMEOUT    = 8'h54;
  localparam logic [7:0] MSG_TOUCH      = 8'h50;
  localparam logic [7:0] RSV_LO         = 8'h50;
  localparam logic [7:0] RSV_HI         = 8'h5f;
  localparam logic [7:0] BULK_LEAD0     = 8'h55;
  localparam logic [7:0] BULK_LEAD1     = 8'haa;
  localparam logic [7:0] STORAGE_IMAGE_WRITE_CMD    = 8'h21;
  localparam logic [7:0] DISPLAY_BLOCK_TRANSFER_CMD = 8'h24;
  localparam logic [7:0] STORAGE_IMAGE_SHOW_CMD     = 8'h22;
  localparam logic [7:0] TOUCH_POLL_CMD             = 8'h03;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int         MAX_PARAMS    = 8;
  localparam logic [3:0] PARAM_LEN_DEF = 4'h4;

  typedef struct packed {
    logic [7:0]              code;
    logic [MAX_PARAMS*8-1:0] params;
    logic [3:0]              nparams;
  } cmd_s;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
  } touch_s;

  // Parameter count per function code; replace with the real table
  function automatic logic [3:0] param_len(input logic [7:0] code);
    if (code == TOUCH_POLL_CMD) begin
      param_len = 4'h0;
    end else begin
      param_len = PARAM_LEN_DEF;
    end
  endfunction

  // Replaceable checksum step: 8-bit wrapping sum
  function automatic logic [7:0] csum_add(input logic [7:0] acc,
                                          input logic [7:0] b);
    csum_add = acc + b;
  endfunction

endpackage

// *** sim/host_link_model.sv ***
`timescale 1ns/1ps
module host_link_model
  import dcl_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Serial link
  output logic      host_txd,
  input  wire logic dev_txd
);
  initial host_txd = 1'b1;

  // ----------------------------------------------------------------
  // Host transmit
  // ----------------------------------------------------------------
  // Bit edges land on the falling clock, away from the sampling edge
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      host_txd = f[i];
      repeat (BIT_CYC - 1) @(negedge mclk);
    end
  endtask

  // Checksum byte may be corrupted on purpose by a nonzero mask
  task automatic send_frame(input logic [7:0] q[$], input logic [7:0] bad);
    logic [7:0] sum;
    sum = 8'h00;
    foreach (q[i]) begin
      send_byte(q[i]);
      sum = sum + q[i];
    end
    send_byte(sum ^ bad);
  endtask

  // ----------------------------------------------------------------
  // Host receive
  // ----------------------------------------------------------------
  task automatic recv_byte(output logic [7:0] b, input int lim,
                           output bit got);
    int n;
    got = 1'b0;
    b = 8'h00;
    n = 0;
    while (dev_txd !== 1'b0 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (dev_txd === 1'b0) begin
      repeat (HALF_BIT) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        b[i] = dev_txd;
      end
      repeat (BIT_CYC) @(posedge mclk);
      got = (dev_txd === 1'b1);
    end
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb
  import dcl_pkg::*;
;
  // Long enough that a busy pause plus a two-byte notice never trips it
  localparam int TMO = 4000;

  logic       mclk;
  logic       arst_n;
  logic       rxd;
  logic       txd;
  logic       cmd_valid;
  cmd_s       cmd;
  logic       engine_busy;
  logic       bulk_valid;
  logic [7:0] bulk_byte;
  logic       bulk_done;
  logic       bulk_ok;
  logic       touch_valid;
  touch_s     touch;
  int         err_total;
  int         n_tests;
  int         n_cmd;
  int         n_bval;
  int         n_bdone;
  logic [7:0] bsum;

  uart_display_command_link #(.RX_TMO_CYC(TMO)) u_uart_display_command_link (
    .mclk(mclk), .arst_n(arst_n), .rxd(rxd), .txd(txd),
    .cmd_valid(cmd_valid), .cmd(cmd), .engine_busy(engine_busy),
    .bulk_valid(bulk_valid), .bulk_byte(bulk_byte), .bulk_done(bulk_done),
    .bulk_ok(bulk_ok), .touch_valid(touch_valid), .touch(touch)
  );

  host_link_model u_host_link_model (
    .mclk(mclk), .host_txd(rxd), .dev_txd(txd)
  );

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (bulk_valid === 1'b1) begin
      n_bval++;
      bsum = bsum + bulk_byte;
    end
    if (bulk_done === 1'b1) n_bdone++;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_msg(input logic [7:0] q[$]);
    logic [7:0] b;
    bit         got;
    foreach (q[i]) begin
      u_host_link_model.recv_byte(b, 6000, got);
      check("reply byte", {23'h0, 1'b1, q[i]}, {23'h0, got, b});
    end
  endtask

  // Raw bytes with no checksum added, for cut or paused frames
  task automatic send_raw(input logic [7:0] q[$]);
    foreach (q[i]) begin
      u_host_link_model.send_byte(q[i]);
    end
  endtask

  task automatic pulse_touch(input logic [15:0] x, input logic [15:0] y);
    @(negedge mclk);
    touch.x = x;
    touch.y = y;
    touch_valid = 1'b1;
    @(negedge mclk);
    touch_valid = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_std_good();
    int c0;
    c0 = n_cmd;
    u_host_link_model.send_frame('{8'h22, 8'h11, 8'h22, 8'h33, 8'h44}, 0);
    expect_msg('{8'h22});
    check("cmd count", 1, n_cmd - c0);
    check("cmd code", 32'h22, cmd.code);
    check("cmd params", 32'h44332211, cmd.params[31:0]);
    check("cmd nparams", 4, cmd.nparams);
  endtask

  task automatic t_bad_sum();
    int c0;
    c0 = n_cmd;
    u_host_link_model.send_frame('{8'h22, 8'h01, 8'h02, 8'h03, 8'h04}, 1);
    expect_msg('{8'h58, 8'h22});
    check("cmd after bad sum", 0, n_cmd - c0);
  endtask

  task automatic t_reserved_poll();
    send_raw('{8'h5a});
    u_host_link_model.send_frame('{8'h03}, 0);
    expect_msg('{8'h03});
    check("poll nparams", 0, cmd.nparams);
  endtask

  task automatic t_timeout();
    int c0;
    c0 = n_cmd;
    send_raw('{8'h22, 8'h01});
    expect_msg('{8'h54, 8'h22});
    check("cmd after timeout", 0, n_cmd - c0);
  endtask

  task automatic t_touch();
    pulse_touch(16'h1234, 16'habcd);
    expect_msg('{8'h50, 8'h12, 8'h34, 8'hab, 8'hcd});
  endtask

  // Touch raised in bulk-wait must vanish, not queue up for later
  task automatic t_bulk_write();
    logic [7:0] b;
    bit         got;
    int         v0;
    int         d0;
    u_host_link_model.send_frame('{8'h21, 8'h01, 8'h02, 8'h03, 8'h04}, 0);
    expect_msg('{8'h21});
    pulse_touch(16'h0102, 16'h0304);
    v0 = n_bval;
    d0 = n_bdone;
    bsum = 8'h00;
    u_host_link_model.send_frame('{8'h55, 8'haa, 8'h01, 8'h3c, 8'hc5}, 0);
    expect_msg('{8'h55, 8'haa});
    check("bulk bytes", 2, n_bval - v0);
    check("bulk data sum", 32'h01, bsum);
    check("bulk done", 1, n_bdone - d0);
    check("bulk ok", 1, bulk_ok);
    u_host_link_model.recv_byte(b, 1500, got);
    check("no touch after bulk", 0, got);
  endtask

  task automatic t_bulk_retry();
    int v0;
    u_host_link_model.send_frame('{8'h24, 8'h00, 8'h00, 8'h10, 8'h10}, 0);
    expect_msg('{8'h24});
    u_host_link_model.send_frame('{8'h55, 8'haa, 8'h00, 8'h7e}, 8'h80);
    expect_msg('{8'h58, 8'h55, 8'haa});
    check("bulk ok on error", 0, bulk_ok);
    v0 = n_bval;
    u_host_link_model.send_frame('{8'h55, 8'haa, 8'h00, 8'h7e}, 0);
    expect_msg('{8'h55, 8'haa});
    check("bulk one byte", 1, n_bval - v0);
  endtask

  task automatic t_busy();
    int c0;
    c0 = n_cmd;
    send_raw('{8'h22, 8'h11, 8'h22});
    @(negedge mclk);
    engine_busy = 1'b1;
    expect_msg('{8'h57, 8'h22});
    @(negedge mclk);
    engine_busy = 1'b0;
    expect_msg('{8'h53, 8'h22});
    send_raw('{8'h33, 8'h44, 8'hcc});
    expect_msg('{8'h22});
    check("cmd after resume", 1, n_cmd - c0);
  endtask

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    engine_busy = 1'b0;
    touch_valid = 1'b0;
    touch = '0;
    err_total = 0;
    n_tests = 0;
    n_cmd = 0;
    n_bval = 0;
    n_bdone = 0;
    bsum = 8'h00;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    check("txd idle", 1, txd);
    t_std_good();
    t_bad_sum();
    t_reserved_poll();
    t_timeout();
    t_touch();
    t_bulk_write();
    t_bulk_retry();
    t_busy();
    tally_and_finish();
  end

  // About 76 serial bytes plus waits come to some 70k clocks; allow 90k
  initial begin
    #(64'd9_000_000);
    err_total++;
    tally_and_finish();
  end
endmodule
